// ==== core/kbd_scan_pkg.sv ====
/*
 * shared constants and carriers for the key matrix scanner.
 * assumes a single 20 MHz clock and a synchronous active-high reset.
 */
package kbd_scan_pkg;
   localparam int         CLK_HZ          = 20_000_000;
   localparam int         NUM_COLS        = 13;
   localparam int         NUM_ROWS        = 8;
   localparam int         NUM_KEYS        = 104;
   localparam int         DEC_COLS        = 12;
   localparam logic [3:0] LAST_DEC_COL    = 4'hb;
   localparam logic [3:0] EXTRA_COL       = 4'hc;
   // column dwell: time for capacitive coupling to settle, in ns
   localparam int         DWELL_NS        = 5000;
   localparam int         DWELL_CYC       = (DWELL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   // serial bit period in ns
   localparam int         BIT_NS          = 10000;
   localparam int         BIT_CYC         = (BIT_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int         KEY_W           = 7;
   localparam logic       LINE_IDLE       = 1'b1;
   localparam logic [6:0] KEY_RST         = 7'h00;

   typedef struct packed {
      logic [3:0] code;   // binary column code to the decoder
      logic       last;   // fifth scan output, inverted for column 13
   } scan_out_s;

   typedef struct packed {
      logic       valid;
      logic [3:0] row;
      logic [3:0] col;
   } hit_s;
endpackage : kbd_scan_pkg

// ==== core/kbd_row_encoder.sv ====
/*
 * row encoder: one-hot row lines in, 4-bit position code out.
 * assumes rows are synchronous levels, high where the strobe couples through.
 */
module kbd_row_encoder #(
   parameter int ROWS = 8
) (
   input  wire logic [ROWS-1:0] rows,
   output logic      [3:0]      code,
   output logic                 hit
);
   // lowest row wins; several rows in one column report only the lowest
   always_comb begin
      code = 4'h0;
      hit  = 1'b0;
      for (int i = ROWS - 1; i >= 0; i--) begin
         if (rows[i]) begin
            code = 4'(i);
            hit  = 1'b1;
         end
      end
   end
endmodule : kbd_row_encoder

// ==== core/kbd_matrix_scanner.sv ====
/*
 * key matrix scanner: column strobes, row encode, key lookup, serial report.
 * assumes row inputs are synchronous to REF_CLK and the receiver samples
 * KEY_SERIAL_LINE at the bit rate with one start bit low and lsb first.
 */
// Operation
// - scan thirteen columns by eight rows, 104 keys
// - five scan outputs: 4-bit code plus one
// - decoder makes twelve column strobes from code
// - strobes one at a time, columns 0 to B
// - column thirteen is inverse of fifth output
// - pressed key routes column strobe to row
// - row encoder gives 4-bit position code
// - code plus column index the key table
// - key number sent serially on one line
module kbd_matrix_scanner #(
   parameter int DWELL = kbd_scan_pkg::DWELL_CYC,
   parameter int BITP  = kbd_scan_pkg::BIT_CYC
) (
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   input  wire logic [7:0]  ROW_IN,
   output logic      [3:0]  COLUMN_CODE_OUTPUTS,
   output logic             LAST_COLUMN_SCAN_OUT,
   output logic      [11:0] COLUMN_STROBE,
   output logic             LAST_COLUMN_STROBE,
   output logic             KEY_SERIAL_LINE
);
   typedef enum logic [2:0] {
      TX_IDLE  = 3'b001,
      TX_START = 3'b010,
      TX_DATA  = 3'b100
   } tx_state_e;

   ////////////////////////////////////////////////////////////////////////////////
   // column scan
   logic [3:0]  col_r;
   logic [15:0] dwell_r;
   logic        col_end;
   assign col_end = (dwell_r == 16'(DWELL - 1));

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         col_r   <= 4'h0;
         dwell_r <= 16'h0000;
      end else if (col_end) begin
         dwell_r <= 16'h0000;
         col_r   <= (col_r == kbd_scan_pkg::EXTRA_COL) ? 4'h0 : col_r + 4'h1;
      end else begin
         dwell_r <= dwell_r + 16'h0001;
      end
   end

   // decoder active-high one-hot; the extra column drives the fifth line low
   function automatic logic [11:0] dec_col(input logic [3:0] c);
      logic [11:0] v;
      v = 12'h000;
      if (c <= kbd_scan_pkg::LAST_DEC_COL) v[c] = 1'b1;
      return v;
   endfunction : dec_col

   kbd_scan_pkg::scan_out_s scan_nxt;
   always_comb begin
      scan_nxt.code = (col_r <= kbd_scan_pkg::LAST_DEC_COL) ? col_r : 4'hf;
      scan_nxt.last = (col_r != kbd_scan_pkg::EXTRA_COL);
   end

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         COLUMN_CODE_OUTPUTS  <= 4'hf;
         LAST_COLUMN_SCAN_OUT <= 1'b1;
         COLUMN_STROBE        <= 12'h000;
         LAST_COLUMN_STROBE   <= 1'b0;
      end else begin
         COLUMN_CODE_OUTPUTS  <= scan_nxt.code;
         LAST_COLUMN_SCAN_OUT <= scan_nxt.last;
         COLUMN_STROBE        <= dec_col(col_r);
         LAST_COLUMN_STROBE   <= ~scan_nxt.last;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // row sense, sampled at the end of the dwell so the strobe has settled
   logic [3:0] row_code;
   logic       row_hit;
   kbd_row_encoder #(.ROWS(kbd_scan_pkg::NUM_ROWS)) u_row_encoder (
      .rows (ROW_IN),
      .code (row_code),
      .hit  (row_hit)
   );

   kbd_scan_pkg::hit_s hit;
   assign hit.valid = col_end & row_hit;
   assign hit.row   = row_code;
   assign hit.col   = col_r;

   // key number = column*8 + row; table holds identity mapping by default
   function automatic logic [6:0] key_index(input logic [3:0] c, input logic [3:0] r);
      return {c, r[2:0]};
   endfunction : key_index

   logic [6:0] key_table [0:127];
   always_comb begin
      for (int i = 0; i < 128; i++) key_table[i] = 7'(i);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // press memory: one bit per key position
   logic [103:0] down_r;
   logic [6:0]   idx;
   logic         fresh;
   logic         tx_busy;
   assign idx   = key_index(hit.col, hit.row);
   assign fresh = hit.valid && !down_r[idx] && !tx_busy;

   // a key that is held while the line is busy stays unmarked and is retried
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         down_r <= '0;
      end else if (col_end) begin
         for (int r = 0; r < kbd_scan_pkg::NUM_ROWS; r++) begin
            if (!ROW_IN[r]) down_r[key_index(col_r, 4'(r))] <= 1'b0;
         end
         if (fresh) down_r[idx] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // serial report: start bit low, seven data bits lsb first, back to idle
   tx_state_e  tx_r;
   logic [6:0] sh_r;
   logic [2:0] bitn_r;
   logic [15:0] bt_r;
   logic        bt_end;
   assign bt_end  = (bt_r == 16'(BITP - 1));
   assign tx_busy = (tx_r != TX_IDLE);

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         tx_r            <= TX_IDLE;
         sh_r            <= kbd_scan_pkg::KEY_RST;
         bitn_r          <= 3'h0;
         bt_r            <= 16'h0000;
         KEY_SERIAL_LINE <= kbd_scan_pkg::LINE_IDLE;
      end else begin
         bt_r <= (tx_r == TX_IDLE || bt_end) ? 16'h0000 : bt_r + 16'h0001;
         case (tx_r)
            TX_IDLE: begin
               if (fresh) begin
                  sh_r            <= key_table[idx];
                  tx_r            <= TX_START;
                  KEY_SERIAL_LINE <= 1'b0;
               end
            end
            TX_START: begin
               if (bt_end) begin
                  tx_r            <= TX_DATA;
                  bitn_r          <= 3'h0;
                  KEY_SERIAL_LINE <= sh_r[0];
                  sh_r            <= {1'b0, sh_r[6:1]};
               end
            end
            TX_DATA: begin
               if (bt_end) begin
                  if (bitn_r == 3'(kbd_scan_pkg::KEY_W - 1)) begin
                     tx_r            <= TX_IDLE;
                     KEY_SERIAL_LINE <= kbd_scan_pkg::LINE_IDLE;
                  end else begin
                     bitn_r          <= bitn_r + 3'h1;
                     KEY_SERIAL_LINE <= sh_r[0];
                     sh_r            <= {1'b0, sh_r[6:1]};
                  end
               end
            end
            default: begin
               tx_r            <= TX_IDLE;
               KEY_SERIAL_LINE <= kbd_scan_pkg::LINE_IDLE;
            end
         endcase
      end
   end
endmodule : kbd_matrix_scanner

// ==== dv/kbd_host_rx.sv ====
/* host receiver model: takes key numbers off the serial line.
   assumes start bit low, seven bits lsb first, BITP cycles a bit. */
module kbd_host_rx #(
   parameter int BITP = 4
) (
   input  wire logic       clk,
   input  wire logic       line,
   output logic      [6:0] key,
   output int              n_rx
);
   timeunit 1ns;
   timeprecision 1ns;
   // samples mid-bit so a slow edge on the line still reads cleanly
   initial begin
      n_rx = 0;
      key = 7'h00;
      forever begin
         @(negedge line);
         repeat (BITP + BITP / 2) @(posedge clk);
         for (int i = 0; i < 7; i++) begin
            key[i] = line;
            // no wait after the last bit, so a frame right behind is not missed
            if (i < 6) repeat (BITP) @(posedge clk);
         end
         n_rx++;
      end
   end
endmodule : kbd_host_rx

// ==== dv/kbd_scan_monitor.sv ====
/* port checker for the key matrix scanner.
   assumes it is bound to the scanner top with its parameters. */
module kbd_scan_monitor #(
   parameter int DWELL = 4,
   parameter int BITP  = 4
) (
   input wire logic        REF_CLK,
   input wire logic        RST,
   input wire logic [3:0]  COLUMN_CODE_OUTPUTS,
   input wire logic        LAST_COLUMN_SCAN_OUT,
   input wire logic [11:0] COLUMN_STROBE,
   input wire logic        LAST_COLUMN_STROBE,
   input wire logic        KEY_SERIAL_LINE
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   logic [3:0] cc;
   logic [3:0] code_r;
   int         dw_r;
   assign cc = COLUMN_CODE_OUTPUTS;
   // run length of the shown column code
   always_ff @(posedge REF_CLK) begin
      code_r <= cc;
      dw_r   <= (cc != code_r) ? 1 : dw_r + 1;
   end
   ////////////////////
   property p_one; $onehot0(COLUMN_STROBE); endproperty
   a_one: assert property (p_one) else $error("strobes overlap");
   property p_dec; cc < 4'hc |-> COLUMN_STROBE == 12'h001 << cc; endproperty
   a_dec: assert property (p_dec) else $error("strobe decode");
   property p_inv; LAST_COLUMN_STROBE == !LAST_COLUMN_SCAN_OUT; endproperty
   a_inv: assert property (p_inv) else $error("last strobe");
   property p_c13; !LAST_COLUMN_SCAN_OUT |-> cc == 4'hf && COLUMN_STROBE == 12'h000; endproperty
   a_c13: assert property (p_c13) else $error("fifth output");
   property p_ord; $changed(cc) && $past(cc) != 4'hb |-> cc == $past(cc) + 4'h1; endproperty
   a_ord: assert property (p_ord) else $error("column order");
   property p_wrap; $fell(LAST_COLUMN_SCAN_OUT) |-> $past(cc) == 4'hb ##4 cc == 4'h0; endproperty
   a_wrap: assert property (p_wrap) else $error("scan wrap");
   property p_dw; $changed(cc) && $past(cc) != 4'hf |-> dw_r == DWELL; endproperty
   a_dw: assert property (p_dw) else $error("column dwell");
   property p_bit; $fell(KEY_SERIAL_LINE) |=> !KEY_SERIAL_LINE [*3]; endproperty
   a_bit: assert property (p_bit) else $error("bit length");
endmodule : kbd_scan_monitor

bind kbd_matrix_scanner kbd_scan_monitor #(.DWELL(DWELL), .BITP(BITP)) mon (
   .REF_CLK(REF_CLK), .RST(RST), .COLUMN_CODE_OUTPUTS(COLUMN_CODE_OUTPUTS),
   .LAST_COLUMN_SCAN_OUT(LAST_COLUMN_SCAN_OUT), .COLUMN_STROBE(COLUMN_STROBE),
   .LAST_COLUMN_STROBE(LAST_COLUMN_STROBE), .KEY_SERIAL_LINE(KEY_SERIAL_LINE));

// ==== dv/kbd_matrix_scanner_tb_top.sv ====
/* self-checking bench: key matrix model, scenarios, verdict.
   assumes short counts of 4 cycles for dwell and bit time. */
module kbd_matrix_scanner_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic [7:0]   rows = 8'h00;
   logic [103:0] pressed = 104'h0;
   logic [11:0]  strb;
   logic         lstrb;
   logic         line;
   logic [6:0]   key;
   int           n_rx;
   int           n_errors = 0;
   int           checks_done = 0;
   always #25 clk = ~clk;
   kbd_matrix_scanner #(.DWELL(4), .BITP(4)) DUT (.REF_CLK(clk), .RST(rst),
      .ROW_IN(rows), .COLUMN_CODE_OUTPUTS(), .LAST_COLUMN_SCAN_OUT(),
      .COLUMN_STROBE(strb), .LAST_COLUMN_STROBE(lstrb), .KEY_SERIAL_LINE(line));
   kbd_host_rx #(.BITP(4)) host (.clk(clk), .line(line), .key(key), .n_rx(n_rx));
   // pressed key couples the live strobe onto its row
   always @(negedge clk) begin
      logic [7:0] r;
      r = 8'h00;
      for (int c = 0; c < 13; c++)
         if ((c < 12) ? strb[c] === 1'b1 : lstrb === 1'b1) r |= pressed[c*8 +: 8];
      rows <= r;
   end
   ////////////////////
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value %s exp %0h got %0h", nm, e, g);
      end
   endtask : chk
   task automatic wait_rx(int n);
      for (int t = 0; t < 400 && n_rx < n; t++) @(negedge clk);
   endtask : wait_rx
   task automatic t_scan();
      @(posedge strb[0]);
      for (int i = 0; i < 60; i++) begin
         @(negedge clk);
         chk("strobe", ((i / 4) % 13 < 12) ? 12'h001 << ((i / 4) % 13) : 12'h000, strb);
         chk("last strobe", (i / 4) % 13 == 12, lstrb);
      end
      $display("test scan done");
   endtask : t_scan
   task automatic t_keys();
      int k [3] = '{0, 43, 103};
      int n;
      foreach (k[j]) begin
         n = n_rx;
         pressed[k[j]] = 1'b1;
         wait_rx(n + 1);
         // key 0 matches the idle value, so the count must move too
         chk("key count", n + 1, n_rx);
         chk("key", k[j], key);
         pressed = 104'h0;
         repeat (120) @(negedge clk);
      end
      $display("test keys done");
   endtask : t_keys
   task automatic t_hold();
      int n;
      n = n_rx;
      pressed[26] = 1'b1;
      repeat (300) @(negedge clk);
      chk("held count", n + 1, n_rx);
      pressed = 104'h0;
      repeat (120) @(negedge clk);
      pressed[26] = 1'b1;
      wait_rx(n + 2);
      chk("repress key", 26, key);
      pressed = 104'h0;
      repeat (120) @(negedge clk);
      $display("test hold done");
   endtask : t_hold
   task automatic t_pair();
      int n;
      int s;
      n = n_rx;
      pressed[8] = 1'b1;
      pressed[16] = 1'b1;
      wait_rx(n + 1);
      s = key;
      repeat (300) @(negedge clk);
      chk("pair count", n + 2, n_rx);
      chk("pair sum", 24, s + key);
      $display("test pair done");
   endtask : t_pair
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      summarize();
   end
   initial begin
      repeat (10) @(negedge clk);
      rst = 1'b0;
      t_scan();
      t_keys();
      t_hold();
      t_pair();
      summarize();
   end
endmodule : kbd_matrix_scanner_tb_top
